// ### src/adc_status_flag_logic.sv
// Converter status flags, result registers and AXI4-Lite register slave
// Contract
// - Data-ready meant to clear on last-result read
// - Channel result read clears data-ready unless an end in the same cycle sets it
// - Last-result read at end keeps data-ready set
// - Channel read at end skips data-ready set when that channel's end flag is set
// - Disable at end stores, data-ready stays low
// - Status read at end freezes general overrun
// - End while data-ready set raises general overrun
// - Status read clears general overrun, except at end
// - Channel read at end may miss general overrun
// - Disable at end misses general overrun when that channel's end flag is set
// - Channel overrun still rises on disable race
// - Own result or last-result read clears end
// - Status read clears overrun unless fresh end
// - Disabled channel end may set on a channel result read
// - Third-channel read clears previous channel end
// - Sleep takes effect after next conversion end
//
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "adc_flag_regs.svh"
module adc_status_flag_logic (
	// Clock and reset
	input  wire logic                      i_clock,
	input  wire logic                      i_rst_b,
	// AXI4-Lite write address and data
	input  wire logic [31:0]               i_s_axi_awaddr,
	input  wire logic                      i_s_axi_awvalid,
	output logic                           o_s_axi_awready,
	input  wire logic [31:0]               i_s_axi_wdata,
	input  wire logic [3:0]                i_s_axi_wstrb,
	input  wire logic                      i_s_axi_wvalid,
	output logic                           o_s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                     o_s_axi_bresp,
	output logic                           o_s_axi_bvalid,
	input  wire logic                      i_s_axi_bready,
	// AXI4-Lite read
	input  wire logic [31:0]               i_s_axi_araddr,
	input  wire logic                      i_s_axi_arvalid,
	output logic                           o_s_axi_arready,
	output logic [31:0]                    o_s_axi_rdata,
	output logic [1:0]                     o_s_axi_rresp,
	output logic                           o_s_axi_rvalid,
	input  wire logic                      i_s_axi_rready,
	// Conversion core
	input  wire logic                      i_eoc,
	input  wire adc_flag_pkg::chan_t       i_eoc_chan,
	input  wire adc_flag_pkg::sample_t     i_eoc_data,
	output adc_flag_pkg::chan_mask_t       o_chan_en,
	output logic                           o_start,
	output logic                           o_sleep
);
	localparam int NCH = adc_flag_pkg::NUM_CH;

	logic                       awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0]                 bresp_q, rresp_q;
	logic [31:0]                rdata_q, awaddr_q, wdata_q;
	logic [3:0]                 wstrb_q;
	logic                       aw_hold_q, w_hold_q;
	adc_flag_pkg::chan_mask_t   chen_q, eoc_f, ovr_f, set_eoc, clr_eoc, set_ovr, clr_ovr;
	adc_flag_pkg::sample_t      cdr_q [NCH];
	adc_flag_pkg::sample_t      lcdr_q;
	adc_flag_pkg::chan_t        last_q;
	logic                       result_ready_q, any_overrun_q, mode_sleep_q, start_q, sleep_q;
	logic [31:0]                rd_data;
	logic                       rd_ok, wr_ok;

	// Bus handshakes and decoded accesses
	wire logic       ar_hs   = i_s_axi_arvalid & arready_q;
	wire logic [7:0] ra      = i_s_axi_araddr[7:0];
	wire logic       ra_hi   = (i_s_axi_araddr[`ADC_ADDR_HI_MSB:`ADC_ADDR_HI_LSB] == '0);
	wire logic       lcdr_rd = ar_hs & ra_hi & (ra == `ADC_LAST_OFF);
	wire logic       sr_rd   = ar_hs & ra_hi & (ra == `ADC_SR_OFF);
	wire logic       cdr_rd  = ar_hs & ra_hi & ((ra & `ADC_CHRES_MASK) == `ADC_CHRES0_OFF);
	wire adc_flag_pkg::chan_t cdr_idx = ra[`ADC_CHRES_IDX_MSB:`ADC_CHRES_IDX_LSB];
	wire logic       wr_go   = aw_hold_q & w_hold_q & ~bvalid_q;
	wire logic [7:0] wa      = awaddr_q[7:0];
	wire logic       wa_hi   = (awaddr_q[`ADC_ADDR_HI_MSB:`ADC_ADDR_HI_LSB] == '0);
	wire logic       wr_b0   = wr_go & wa_hi & wstrb_q[0];
	wire logic       ctrl_wr = wr_b0 & (wa == `ADC_CTRL_OFF);
	wire logic       mode_wr = wr_b0 & (wa == `ADC_MODE_OFF);
	wire logic       en_wr   = wr_b0 & (wa == `ADC_CHEN_OFF);
	wire logic       dis_wr  = wr_b0 & (wa == `ADC_CHDIS_OFF) & (wdata_q[NCH-1:0] != '0);

	// Conversion end qualifiers
	wire logic       store   = i_eoc & chen_q[i_eoc_chan];
	wire logic       eoc_x   = eoc_f[i_eoc_chan];

	// Write address and data capture, either order
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			awaddr_q  <= '0;
			wdata_q   <= '0;
			wstrb_q   <= '0;
		end
		else
		begin
			if (i_s_axi_awvalid & awready_q)
			begin
				awaddr_q  <= i_s_axi_awaddr;
				aw_hold_q <= 1'b1;
				awready_q <= 1'b0;
			end
			else if (wr_go)
			begin
				aw_hold_q <= 1'b0;
				awready_q <= 1'b1;
			end
			if (i_s_axi_wvalid & wready_q)
			begin
				wdata_q  <= i_s_axi_wdata;
				wstrb_q  <= i_s_axi_wstrb;
				w_hold_q <= 1'b1;
				wready_q <= 1'b0;
			end
			else if (wr_go)
			begin
				w_hold_q <= 1'b0;
				wready_q <= 1'b1;
			end
		end
	end

	// Writable offsets
	always_comb
	begin
		wr_ok = 1'b0;
		if (!wa_hi)
			wr_ok = 1'b0;
		else if (wa == `ADC_CTRL_OFF || wa == `ADC_MODE_OFF)
			wr_ok = 1'b1;
		else if (wa == `ADC_CHEN_OFF || wa == `ADC_CHDIS_OFF)
			wr_ok = 1'b1;
	end

	// Write response
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			bvalid_q <= 1'b0;
			bresp_q  <= `ADC_RESP_OKAY;
		end
		else if (wr_go)
		begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_ok ? `ADC_RESP_OKAY : `ADC_RESP_SLVERR;
		end
		else if (i_s_axi_bready)
			bvalid_q <= 1'b0;
	end

	// Read data selection
	always_comb
	begin
		rd_data = '0;
		rd_ok   = 1'b1;
		if (!ra_hi)
			rd_ok = 1'b0;
		else if (ra == `ADC_MODE_OFF)
			rd_data[`ADC_MODE_SLEEP] = mode_sleep_q;
		else if (ra == `ADC_CHSR_OFF)
			rd_data[NCH-1:0] = chen_q;
		else if (ra == `ADC_SR_OFF)
		begin
			rd_data[NCH-1:0] = eoc_f;
			rd_data[`ADC_SR_OVR_LSB +: NCH] = ovr_f;
			rd_data[`ADC_SR_READY] = result_ready_q;
			rd_data[`ADC_SR_ANYOVR] = any_overrun_q;
		end
		else if (ra == `ADC_LAST_OFF)
		begin
			rd_data[adc_flag_pkg::DATA_W-1:0] = lcdr_q;
			rd_data[`ADC_LAST_CH_LSB +: 3] = last_q;
		end
		else if ((ra & `ADC_CHRES_MASK) == `ADC_CHRES0_OFF)
			rd_data[adc_flag_pkg::DATA_W-1:0] = cdr_q[cdr_idx];
		else if (ra == `ADC_CTRL_OFF || ra == `ADC_CHEN_OFF || ra == `ADC_CHDIS_OFF)
			rd_data = '0;
		else
			rd_ok = 1'b0;
	end

	// Read channel, answer one cycle after the address is taken
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= '0;
			rresp_q   <= `ADC_RESP_OKAY;
		end
		else if (ar_hs)
		begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= rd_data;
			rresp_q   <= rd_ok ? `ADC_RESP_OKAY : `ADC_RESP_SLVERR;
		end
		else if (rvalid_q & i_s_axi_rready)
		begin
			rvalid_q  <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	// Channel enables, set and disable writes
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
			chen_q <= `ADC_CHEN_RST;
		else if (en_wr)
			chen_q <= chen_q | wdata_q[NCH-1:0];
		else if (dis_wr)
			chen_q <= chen_q & ~wdata_q[NCH-1:0];
	end

	// Result storage, still stored on a disable race
	// store despite disable
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			lcdr_q <= '0;
			last_q <= `ADC_CHAN_RST;
			for (int i = 0; i < NCH; i++)
				cdr_q[i] <= '0;
		end
		else if (store)
		begin
			lcdr_q             <= i_eoc_data;
			last_q             <= i_eoc_chan;
			cdr_q[i_eoc_chan]  <= i_eoc_data;
		end
	end

	// Per-channel flag strobes
	always_comb
	begin
		for (int i = 0; i < NCH; i++)
		begin
			set_eoc[i] = i_eoc & (i_eoc_chan == i[2:0]) & (chen_q[i] | cdr_rd);
			set_ovr[i] = store & (i_eoc_chan == i[2:0]) & eoc_f[i];
			clr_eoc[i] = (lcdr_rd & (last_q == i[2:0]))
				| (cdr_rd & (cdr_idx == i[2:0]) & ~(i_eoc & cdr_idx != i_eoc_chan
					& cdr_idx != last_q));
			if (cdr_rd & i_eoc & cdr_idx != i_eoc_chan & cdr_idx != last_q
				& last_q == i[2:0])
				clr_eoc[i] = 1'b1;
			clr_ovr[i] = sr_rd & ~(i_eoc & (i_eoc_chan == i[2:0]) & ~eoc_f[i]);
		end
	end

	// Flag pair of each channel
	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : g_ch
			adc_chan_flags u_flags (
				.i_clock   (i_clock),
				.i_rst_b   (i_rst_b),
				.i_set_eoc (set_eoc[g]),
				.i_clr_eoc (clr_eoc[g]),
				.i_set_ovr (set_ovr[g]),
				.i_clr_ovr (clr_ovr[g]),
				.o_eoc     (eoc_f[g]),
				.o_ovr     (ovr_f[g])
			);
		end
	endgenerate

	// Data-ready flag with its read and end races
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
			result_ready_q <= 1'b0;
		else if (lcdr_rd & i_eoc & result_ready_q)
			result_ready_q <= 1'b1;
		else if (store & ~dis_wr & ~(cdr_rd & eoc_x))
			result_ready_q <= 1'b1;
		else if (lcdr_rd | cdr_rd)
			result_ready_q <= 1'b0;
	end

	// General overrun flag
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
			any_overrun_q <= 1'b0;
		else if (sr_rd & i_eoc)
			any_overrun_q <= any_overrun_q;
		else if (store & result_ready_q
			& ~(cdr_rd & eoc_x & ~any_overrun_q
				& last_q != i_eoc_chan & last_q != cdr_idx)
			& ~(dis_wr & eoc_x))
			any_overrun_q <= 1'b1;
		else if (sr_rd)
			any_overrun_q <= 1'b0;
	end

	// Sleep mode bit and start strobe
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			mode_sleep_q <= `ADC_MODE_RST;
			start_q      <= 1'b0;
		end
		else
		begin
			if (mode_wr)
				mode_sleep_q <= wdata_q[`ADC_MODE_SLEEP];
			start_q <= ctrl_wr & wdata_q[`ADC_CTRL_START];
		end
	end

	// Converter sleep, entered only at a conversion end
	// deferred sleep entry
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
			sleep_q <= 1'b0;
		else if (!mode_sleep_q || start_q)
			sleep_q <= 1'b0;
		else if (i_eoc)
			sleep_q <= 1'b1;
	end

	assign o_s_axi_awready = awready_q;
	assign o_s_axi_wready  = wready_q;
	assign o_s_axi_bvalid  = bvalid_q;
	assign o_s_axi_bresp   = bresp_q;
	assign o_s_axi_arready = arready_q;
	assign o_s_axi_rvalid  = rvalid_q;
	assign o_s_axi_rdata   = rdata_q;
	assign o_s_axi_rresp   = rresp_q;
	assign o_chan_en       = chen_q;
	assign o_start         = start_q;
	assign o_sleep         = sleep_q;

	// Checks on flag behaviour
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);

	sequence dis_race_s;
		dis_wr && store && !result_ready_q && !lcdr_rd && !cdr_rd;
	endsequence
	sequence stored_no_ready_s;
		!result_ready_q && lcdr_q == $past(i_eoc_data);
	endsequence
	sequence idle_sleep_s;
		mode_sleep_q && !sleep_q && !i_eoc && !start_q;
	endsequence

	cdr_clr_ready_a: assert property (cdr_rd && !i_eoc |=> !result_ready_q)
		else $error("channel read left data-ready set");
	lcdr_keep_a: assert property (lcdr_rd && i_eoc && result_ready_q |=> result_ready_q)
		else $error("data-ready dropped on last-result race");
	ready_skip_a: assert property (cdr_rd && store && eoc_x && !lcdr_rd
		|=> !result_ready_q)
		else $error("data-ready set despite channel read race");
	dis_race_a: assert property (dis_race_s |=> stored_no_ready_s)
		else $error("disable race handled wrongly");
	sr_freeze_a: assert property (sr_rd && i_eoc |=> $stable(any_overrun_q))
		else $error("general overrun changed on status race");
	any_ovr_set_a: assert property (store && result_ready_q && !sr_rd && !cdr_rd && !dis_wr
		|=> any_overrun_q)
		else $error("general overrun not raised");
	sr_clr_a: assert property (sr_rd && !i_eoc |=> !any_overrun_q)
		else $error("status read did not clear general overrun");
	ovr_clr_a: assert property (sr_rd && !i_eoc |=> ovr_f == '0)
		else $error("status read did not clear channel overrun");
	any_ovr_dis_a: assert property (dis_wr && store && eoc_x && result_ready_q
		&& !any_overrun_q && !sr_rd |=> !any_overrun_q)
		else $error("general overrun raised on disable race");
	lcdr_clr_a: assert property (lcdr_rd && !i_eoc ##1 1 |-> !eoc_f[$past(last_q)])
		else $error("last-result read kept end flag");
	ovr_rise_a: assert property (store && eoc_x |=> ovr_f[$past(i_eoc_chan)])
		else $error("channel overrun not raised");
	sleep_wait_a: assert property (idle_sleep_s |=> !sleep_q)
		else $error("sleep entered without conversion end");
	sleep_enter_a: assert property (i_eoc && mode_sleep_q && !start_q && !mode_wr
		&& !ctrl_wr |=> sleep_q [*2])
		else $error("sleep not entered after conversion end");
endmodule : adc_status_flag_logic

// ### src/adc_flag_regs.svh
// Register map, field positions and reset values of the converter flag block
`ifndef ADC_FLAG_REGS_SVH
`define ADC_FLAG_REGS_SVH

// Byte offsets in the low address byte
`define ADC_CTRL_OFF     8'h00
`define ADC_MODE_OFF     8'h04
`define ADC_CHEN_OFF     8'h10
`define ADC_CHDIS_OFF    8'h14
`define ADC_CHSR_OFF     8'h18
`define ADC_SR_OFF       8'h1c
`define ADC_LAST_OFF     8'h20
`define ADC_CHRES0_OFF   8'h40
`define ADC_CHRES_MASK   8'he3

// Address slicing
`define ADC_ADDR_HI_MSB  31
`define ADC_ADDR_HI_LSB  8
`define ADC_CHRES_IDX_MSB 4
`define ADC_CHRES_IDX_LSB 2

// Field positions
`define ADC_CTRL_START   0
`define ADC_MODE_SLEEP   0
`define ADC_SR_OVR_LSB   8
`define ADC_SR_READY     16
`define ADC_SR_ANYOVR    17
`define ADC_LAST_CH_LSB  12

// Reset values
`define ADC_CHEN_RST     8'h00
`define ADC_MODE_RST     1'b0
`define ADC_CHAN_RST     3'h0

// Bus answers
`define ADC_RESP_OKAY    2'b00
`define ADC_RESP_SLVERR  2'b10

`endif

// ### src/adc_flag_pkg.sv
// Shared types of the converter flag block
package adc_flag_pkg;
	localparam int NUM_CH = 8;
	localparam int DATA_W = 10;
	typedef logic [2:0]          chan_t;
	typedef logic [NUM_CH-1:0]   chan_mask_t;
	typedef logic [DATA_W-1:0]   sample_t;
endpackage : adc_flag_pkg

// ### src/adc_chan_flags.sv
// End-of-conversion and overrun flag pair of one channel
`timescale 1ns/1ps
module adc_chan_flags (
	// Clock and reset
	input  wire logic i_clock,
	input  wire logic i_rst_b,
	// Set and clear strobes
	input  wire logic i_set_eoc,
	input  wire logic i_clr_eoc,
	input  wire logic i_set_ovr,
	input  wire logic i_clr_ovr,
	// Flags
	output logic      o_eoc,
	output logic      o_ovr
);
	logic eoc_q;
	logic ovr_q;

	// End flag, set wins over clear
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
			eoc_q <= 1'b0;
		else if (i_set_eoc)
			eoc_q <= 1'b1;
		else if (i_clr_eoc)
			eoc_q <= 1'b0;
	end

	// Overrun flag, set wins over clear
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
			ovr_q <= 1'b0;
		else if (i_set_ovr)
			ovr_q <= 1'b1;
		else if (i_clr_ovr)
			ovr_q <= 1'b0;
	end

	assign o_eoc = eoc_q;
	assign o_ovr = ovr_q;
endmodule : adc_chan_flags

// ### bench/testbench.sv
// Self-checking bench of the converter flag block against a flag model
`timescale 1ns/1ps
`include "adc_flag_regs.svh"
module testbench;
	// Design ports
	logic                     i_clock, i_rst_b, awvalid, wvalid, bready, arvalid, rready;
	logic                     awready, wready, bvalid, arready, rvalid, eoc, start, sleep;
	logic [31:0]              awaddr, wdata, araddr, rdata;
	logic [1:0]               bresp, rresp;
	adc_flag_pkg::chan_t      eoc_chan;
	adc_flag_pkg::sample_t    eoc_data;
	adc_flag_pkg::chan_mask_t chan_en;
	// Bench state and reference model
	int                       miscompares, checks_done, ch, d;
	int                       m_eoc, m_ovr, m_ready, m_gov, m_last, m_en, m_lcd;
	int                       m_cdr [8];
	logic [31:0]              got;
	logic [1:0]               resp;
	logic                     start_seen;

	adc_status_flag_logic i_dut (
		.i_clock(i_clock), .i_rst_b(i_rst_b),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
		.i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
		.i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
		.o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_eoc(eoc),
		.i_eoc_chan(eoc_chan), .i_eoc_data(eoc_data), .o_chan_en(chan_en),
		.o_start(start), .o_sleep(sleep)
	);

	// Clock at 25 MHz
	initial
	begin
		i_clock = 1'b0;
		forever #20 i_clock = ~i_clock;
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Register write, optionally with an end of conversion at the write edge
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] v, input logic fire);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge i_clock);
			aw_done = aw_done || awready === 1'b1;
			w_done = w_done || wready === 1'b1;
			awvalid <= !aw_done;
			wvalid <= !w_done;
		end
		if (fire)
			eoc <= 1'b1;
		@(posedge i_clock);
		if (fire)
			eoc <= 1'b0;
		do
			@(posedge i_clock);
		while (bvalid !== 1'b1);
		start_seen = start;
		resp = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	// Register read, optionally with an end of conversion at the take edge
	task automatic axi_rd(input logic [31:0] a, input logic fire);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		if (fire)
			eoc <= 1'b1;
		do
			@(posedge i_clock);
		while (arready !== 1'b1);
		arvalid <= 1'b0;
		if (fire)
			eoc <= 1'b0;
		do
			@(posedge i_clock);
		while (rvalid !== 1'b1);
		got = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	// Model of one end of conversion
	function automatic void model_end(input int c, input int v);
		if (m_en[c])
		begin
			if (m_eoc[c])
				m_ovr |= 1 << c;
			if (m_ready)
				m_gov = 1;
			m_eoc |= 1 << c;
			m_ready = 1;
			m_cdr[c] = v;
			m_last = c;
			m_lcd = v;
		end
	endfunction : model_end

	// One conversion pulse, then an idle cycle
	task automatic conv(input int c, input int v);
		eoc_chan <= 3'(c);
		eoc_data <= 10'(v);
		eoc <= 1'b1;
		@(posedge i_clock);
		eoc <= 1'b0;
		@(posedge i_clock);
		model_end(c, v);
	endtask : conv

	task automatic rd_chk(input string what, input logic [31:0] a, input int exp);
		axi_rd(a, 1'b0);
		check(what, exp, got);
		check("rresp", `ADC_RESP_OKAY, resp);
	endtask : rd_chk

	// Status read with its clearing side effects
	task automatic sr_chk();
		rd_chk("status", `ADC_SR_OFF, m_gov << 17 | m_ready << 16 | m_ovr << 8 | m_eoc);
		m_ovr = 0;
		m_gov = 0;
	endtask : sr_chk

	task automatic cdr_chk(input int c);
		rd_chk("chan_result", `ADC_CHRES0_OFF + 4 * c, m_cdr[c]);
		m_eoc &= ~(1 << c);
		m_ready = 0;
	endtask : cdr_chk

	// Reset, reset-value checks, all channels enabled
	task automatic do_reset();
		i_rst_b <= 1'b0;
		repeat (8) @(posedge i_clock);
		check("rst_ready", 3'b111, {awready, wready, arready});
		check("rst_valid", 2'b00, {bvalid, rvalid});
		check("rst_out", 10'h000, {chan_en, start, sleep});
		i_rst_b <= 1'b1;
		{m_eoc, m_ovr, m_ready, m_gov, m_last, m_lcd} = '0;
		m_cdr = '{default: 0};
		rd_chk("mode_rst", `ADC_MODE_OFF, 0);
		rd_chk("chsr_rst", `ADC_CHSR_OFF, 0);
		axi_wr(`ADC_CHEN_OFF, 32'h0000_00ff, 1'b0);
		m_en = 'hff;
		rd_chk("chsr", `ADC_CHSR_OFF, m_en);
	endtask : do_reset

	task automatic summarize();
		if (miscompares == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize

	// Watchdog
	initial
	begin
		repeat (20000) @(posedge i_clock);
		miscompares++;
		summarize();
	end

	// Main sequence
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready, eoc} = '0;
		{awaddr, wdata, araddr, eoc_chan, eoc_data} = '0;
		i_rst_b = 1'b0;
		m_cdr = '{default: 0};
		void'($urandom(32'h89af72f7));
		do_reset();
		// Unmapped accesses are refused
		axi_rd(32'h0000_0008, 1'b0);
		check("unmapped_rd", 32'h0, got);
		check("unmapped_rresp", `ADC_RESP_SLVERR, resp);
		axi_wr(32'h0000_000c, 32'h0000_00ff, 1'b0);
		check("unmapped_wr", `ADC_RESP_SLVERR, resp);
		// Random conversions and reads against the model
		for (int i = 0; i < 60; i++)
		begin
			ch = $urandom_range(7);
			conv(ch, $urandom_range(1023));
			case ($urandom_range(3))
				0: sr_chk();
				1:
				begin
					rd_chk("last", `ADC_LAST_OFF, m_last << 12 | m_lcd);
					m_eoc &= ~(1 << m_last);
					m_ready = 0;
				end
				2: cdr_chk(ch);
				default: ;
			endcase
		end
		do_reset();
		// Channel read at an end on another channel, last stored is a third one
		conv(1, 'h111);
		conv(2, 'h222);
		sr_chk();
		eoc_chan <= 3'd1;
		eoc_data <= 10'h333;
		axi_rd(`ADC_CHRES0_OFF + 12, 1'b1);
		check("chan3_race", m_cdr[3], got);
		{m_eoc, m_ovr, m_ready, m_gov} = {32'd2, 32'd2, 32'd0, 32'd0};
		{m_last, m_lcd} = {32'd1, 32'h333};
		m_cdr[1] = 'h333;
		sr_chk();
		// Status read at an end while data-ready is set
		conv(4, 'h044);
		eoc_chan <= 3'd5;
		eoc_data <= 10'h055;
		axi_rd(`ADC_SR_OFF, 1'b1);
		check("sr_race", m_ready << 16 | m_eoc, got);
		model_end(5, 'h055);
		m_gov = 0;
		m_ovr = 0;
		sr_chk();
		// Channel disable at an end with end flag and data-ready set
		eoc_chan <= 3'd5;
		eoc_data <= 10'h2a5;
		axi_wr(`ADC_CHDIS_OFF, 32'h0000_0040, 1'b1);
		model_end(5, 'h2a5);
		m_gov = 0;
		m_en = 'hbf;
		check("chan_en", 8'hbf, chan_en);
		sr_chk();
		cdr_chk(5);
		rd_chk("last", `ADC_LAST_OFF, 5 << 12 | 'h2a5);
		// Channel disable at an end with data-ready clear
		eoc_data <= 10'h1a5;
		axi_wr(`ADC_CHDIS_OFF, 32'h0000_0080, 1'b1);
		model_end(5, 'h1a5);
		m_ready = 0;
		m_en = 'h3f;
		check("chan_en", 8'h3f, chan_en);
		sr_chk();
		rd_chk("last", `ADC_LAST_OFF, 5 << 12 | 'h1a5);
		m_eoc &= ~(1 << 5);
		// Last-result read at an end on a disabled channel
		conv(0, 'h100);
		eoc_chan <= 3'd6;
		eoc_data <= 10'h3ff;
		axi_rd(`ADC_LAST_OFF, 1'b1);
		check("last_race", 32'h0000_0100, got);
		m_eoc &= ~1;
		sr_chk();
		// Channel read at an end on a disabled channel
		axi_rd(`ADC_CHRES0_OFF, 1'b1);
		check("chan_race", m_cdr[0], got);
		m_eoc |= 'h40;
		m_ready = 0;
		sr_chk();
		// Sleep waits for the next conversion end
		axi_wr(`ADC_MODE_OFF, 32'h0000_0001, 1'b0);
		rd_chk("mode", `ADC_MODE_OFF, 1);
		repeat (4) @(posedge i_clock);
		check("sleep_idle", 1'b0, sleep);
		conv(3, 'h0c3);
		repeat (2) @(negedge i_clock);
		check("sleep_after_end", 1'b1, sleep);
		axi_wr(`ADC_CTRL_OFF, 32'h0000_0001, 1'b0);
		check("start_pulse", 1'b1, start_seen);
		@(negedge i_clock);
		check("start_pulse_end", 1'b0, start);
		check("sleep_woken", 1'b0, sleep);
		@(posedge i_clock);
		conv(2, 'h0aa);
		@(negedge i_clock);
		check("sleep_again", 1'b1, sleep);
		summarize();
	end
endmodule : testbench
